/* File: core/lms_pkg.sv */
// Package of constants and carrier types for the run/stop sequencer
package lms_pkg;

	localparam int LMS_DI_N = 24;
	localparam int LMS_AI_N = 8;
	localparam int LMS_AI_W = 10;
	localparam int LMS_Q_N = 16;
	localparam int LMS_M_N = 8;
	localparam int LMS_SLOTS = 4;
	localparam int LMS_BASE_DI = 8;
	localparam int LMS_BASE_Q = 4;
	localparam int LMS_DI_PER_SLOT = 4;
	localparam int LMS_Q_PER_SLOT = 3;
	localparam int LMS_DUAL_N = 2;
	localparam int LMS_DUAL_POS = 6;
	localparam int LMS_RETAIN_WAIT = 4;

	localparam logic LMS_ONE = 1'h1;
	localparam logic LMS_ZERO = 1'h0;
	localparam logic [LMS_Q_N-1:0] LMS_Q_OFF = 16'h0000;
	localparam logic [LMS_M_N-1:0] LMS_M_CLR = 8'h00;
	localparam logic [LMS_AI_W-1:0] LMS_AI_CLR = 10'h000;

	typedef enum logic [7:0] {
		LMS_ST_BOOT = 8'h01,
		LMS_ST_CHECK = 8'h02,
		LMS_ST_COPY = 8'h04,
		LMS_ST_NOPROG = 8'h08,
		LMS_ST_STOP = 8'h10,
		LMS_ST_READ = 8'h20,
		LMS_ST_EVAL = 8'h40,
		LMS_ST_WRITE = 8'h80
	} lms_state_e;

	typedef struct packed {
		logic [LMS_DI_N-1:0] di;
		logic [LMS_AI_N-1:0][LMS_AI_W-1:0] ai;
		logic [LMS_M_N-1:0] m;
		logic one;
		logic zero;
	} lms_image_s;

	typedef struct packed {
		logic [LMS_Q_N-1:0] q;
		logic [LMS_M_N-1:0] m;
	} lms_result_s;

	typedef struct packed {
		logic stored_valid;
		logic module_valid;
		logic saved_run;
		logic entry_cut;
		logic retain_any;
	} lms_nv_s;

endpackage

/* File: core/lms_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module lms_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_q;

	// Accept a bit only when stages two and three agree
	always_comb begin
		next_q = q;
		for (int i = 0; i < W; i++) begin
			if (s2[i] == s3[i]) begin
				next_q[i] = s3[i];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q <= '0;
		end else if (ce) begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q <= next_q;
		end
	end

endmodule

/* File: core/lms_sequencer.sv */
// Operation:
// - No program anywhere at power-up: display unit shows no-program prompt.
// - Program in plug-in module is copied inside, overwriting the stored one.
// - With a valid program, power-up resumes the saved stop or run state.
// - Display-less unit with a program goes from stop to run itself.
// - Retentive values are preserved across a power loss.
// - Power lost during program entry discards the stored program.
// - Stop: inputs not read, program not run, all outputs off.
// - Run: read inputs, evaluate program, then drive outputs, repeatedly.
// - Display-less status lamp is red in stop, green in run.
// - Provides 24 digital, 8 analog inputs, 16 outputs, 8 flag bits.
// - Dual-use pins seven and eight are digital or analog per program.
// - Expansion I/O is handled and numbered in physical module order.
// - Constant one and constant zero sources are offered to the program.
`timescale 1ns/100ps
module lms_sequencer
	import lms_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic displayless_variant,
	input wire lms_nv_s nv,
	input wire logic copy_done,
	input wire logic start_cmd,
	input wire logic stop_cmd,
	input wire logic power_fail_pin,
	input wire logic [LMS_DI_N-1:0] digital_input_range,
	input wire logic [LMS_AI_N-1:0][LMS_AI_W-1:0] analog_channel_range,
	input wire logic [LMS_DUAL_N-1:0] dual_use_analog,
	input wire logic [LMS_SLOTS-1:0] slot_comm,
	input wire logic [LMS_M_N-1:0] retained_flags,
	input wire logic eval_done,
	input wire lms_result_s eval_result,
	output lms_image_s image,
	output logic scan_req,
	output logic [LMS_Q_N-1:0] switched_output_range,
	output logic [LMS_M_N-1:0] flag_bit_range,
	output logic run_state,
	output logic prompt_no_prog,
	output logic copy_req,
	output logic discard_prog,
	output logic retain_store,
	output logic retain_restore,
	output logic led_green,
	output logic led_red
);

	lms_state_e state;
	lms_state_e next_state;
	logic strap_dl;
	logic next_strap_dl;
	logic next_scan_req, next_prompt, next_copy_req, next_discard;
	logic next_restore, next_store, next_green, next_red, next_run;
	logic pf_prev, next_pf_prev;
	logic pf_sync;
	logic [LMS_DI_N-1:0] di_sync, di_mask;
	logic [LMS_Q_N-1:0] q_mask;
	lms_image_s next_image;
	logic [LMS_Q_N-1:0] next_q;
	logic [LMS_M_N-1:0] next_m;
	logic has_prog, resume_run;

	// Digital input and power-fail pins pass the three-stage synchroniser; analog channels do not
	lms_sync #(.W(LMS_DI_N + 1)) u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d({power_fail_pin, digital_input_range}),
		.q({pf_sync, di_sync})
	);

	always_comb begin
		di_mask = '0;
		q_mask = '0;
		di_mask[LMS_BASE_DI-1:0] = '1;
		q_mask[LMS_BASE_Q-1:0] = '1;
		for (int s = 0; s < LMS_SLOTS; s++) begin
			for (int b = 0; b < LMS_DI_PER_SLOT; b++) begin
				di_mask[LMS_BASE_DI + s*LMS_DI_PER_SLOT + b] = slot_comm[s];
			end
			for (int b = 0; b < LMS_Q_PER_SLOT; b++) begin
				q_mask[LMS_BASE_Q + s*LMS_Q_PER_SLOT + b] = slot_comm[s];
			end
		end
	end

	assign has_prog = nv.stored_valid & ~nv.entry_cut;
	assign resume_run = nv.saved_run | strap_dl;

	// Sequencing of power-up and run/stop
	always_comb begin
		next_state = state;
		next_strap_dl = strap_dl;
		next_scan_req = 1'h0;
		next_copy_req = copy_req;
		next_discard = 1'h0;
		next_restore = 1'h0;
		next_store = 1'h0;
		next_pf_prev = pf_sync;
		unique case (state)
			LMS_ST_BOOT: begin
				next_strap_dl = displayless_variant;
				next_state = LMS_ST_CHECK;
			end
			LMS_ST_CHECK: begin
				next_discard = nv.entry_cut;
				if (nv.module_valid) begin
					next_copy_req = 1'h1;
					next_state = LMS_ST_COPY;
				end else if (has_prog) begin
					next_restore = nv.retain_any;
					next_state = resume_run ? LMS_ST_READ : LMS_ST_STOP;
				end else begin
					next_state = LMS_ST_NOPROG;
				end
			end
			LMS_ST_COPY: begin
				if (copy_done) begin
					next_copy_req = 1'h0;
					next_restore = nv.retain_any;
					next_state = resume_run ? LMS_ST_READ : LMS_ST_STOP;
				end
			end
			LMS_ST_NOPROG, LMS_ST_STOP: begin
				if (start_cmd && nv.stored_valid) begin
					next_state = LMS_ST_READ;
				end
			end
			LMS_ST_READ: begin
				next_scan_req = ~stop_cmd;
				next_state = stop_cmd ? LMS_ST_STOP : LMS_ST_EVAL;
			end
			LMS_ST_EVAL: begin
				if (stop_cmd) begin
					next_state = LMS_ST_STOP;
				end else if (eval_done) begin
					next_state = LMS_ST_WRITE;
				end
			end
			LMS_ST_WRITE: begin
				next_state = stop_cmd ? LMS_ST_STOP : LMS_ST_READ;
			end
			default: begin
				next_state = LMS_ST_BOOT;
			end
		endcase
		if (pf_sync && !pf_prev && nv.retain_any) begin
			next_store = 1'h1;
		end
		next_run = (next_state == LMS_ST_READ) || (next_state == LMS_ST_EVAL)
			|| (next_state == LMS_ST_WRITE);
		next_prompt = (next_state == LMS_ST_NOPROG) && !next_strap_dl;
		next_green = next_strap_dl && next_run;
		next_red = next_strap_dl && !next_run;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= LMS_ST_BOOT;
			strap_dl <= 1'h0;
			scan_req <= 1'h0;
			copy_req <= 1'h0;
			discard_prog <= 1'h0;
			retain_restore <= 1'h0;
			retain_store <= 1'h0;
			pf_prev <= 1'h0;
			run_state <= 1'h0;
			prompt_no_prog <= 1'h0;
			led_green <= 1'h0;
			led_red <= 1'h0;
		end else if (ce) begin
			state <= next_state;
			strap_dl <= next_strap_dl;
			scan_req <= next_scan_req;
			copy_req <= next_copy_req;
			discard_prog <= next_discard;
			retain_restore <= next_restore;
			retain_store <= next_store;
			pf_prev <= next_pf_prev;
			run_state <= next_run;
			prompt_no_prog <= next_prompt;
			led_green <= next_green;
			led_red <= next_red;
		end
	end

	// Process image, outputs and flags
	always_comb begin
		next_image = image;
		next_q = switched_output_range;
		next_m = flag_bit_range;
		if (retain_restore) begin
			next_m = retained_flags;
		end
		unique case (state)
			LMS_ST_READ: begin
				next_image.di = di_sync & di_mask;
				next_image.ai = analog_channel_range;
				next_image.m = flag_bit_range;
				for (int k = 0; k < LMS_DUAL_N; k++) begin
					if (dual_use_analog[k]) begin
						next_image.di[LMS_DUAL_POS + k] = LMS_ZERO;
					end else begin
						next_image.ai[k] = LMS_AI_CLR;
					end
				end
			end
			LMS_ST_EVAL: begin
				if (eval_done && !stop_cmd) begin
					next_q = eval_result.q & q_mask;
					next_m = eval_result.m;
				end
			end
			default: begin
			end
		endcase
		next_image.one = LMS_ONE;
		next_image.zero = LMS_ZERO;
		if (!next_run) begin
			next_q = LMS_Q_OFF;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			image <= '{di: '0, ai: '0, m: LMS_M_CLR,
				one: LMS_ONE, zero: LMS_ZERO};
			switched_output_range <= LMS_Q_OFF;
			flag_bit_range <= LMS_M_CLR;
		end else if (ce) begin
			image <= next_image;
			switched_output_range <= next_q;
			flag_bit_range <= next_m;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_stop_off;
		ce && state == LMS_ST_STOP |-> switched_output_range == LMS_Q_OFF;
	endproperty
	a_stop_off: assert property (p_stop_off)
		else $error("outputs active in stop");
	sequence s_stop_run;
		ce && run_state && stop_cmd && state != LMS_ST_WRITE;
	endsequence
	property p_stop_clear;
		s_stop_run |=> state == LMS_ST_STOP && switched_output_range == '0;
	endproperty
	a_stop_clear: assert property (p_stop_clear)
		else $error("outputs kept after stop");
	property p_copy;
		ce && state == LMS_ST_CHECK && nv.module_valid
			|=> copy_req && state == LMS_ST_COPY;
	endproperty
	a_copy: assert property (p_copy)
		else $error("module program not copied");
	property p_prompt;
		ce && state == LMS_ST_CHECK && !nv.module_valid && !has_prog
			&& !strap_dl |=> prompt_no_prog;
	endproperty
	a_prompt: assert property (p_prompt)
		else $error("no-program prompt missing");
	property p_resume;
		ce && state == LMS_ST_COPY && copy_done && nv.saved_run
			|=> state == LMS_ST_READ && run_state;
	endproperty
	a_resume: assert property (p_resume)
		else $error("saved run state not resumed");
	property p_lamp;
		strap_dl |-> led_green == run_state && led_red == !run_state;
	endproperty
	a_lamp: assert property (p_lamp)
		else $error("status lamp wrong");
	sequence s_read;
		ce && state == LMS_ST_READ && !stop_cmd;
	endsequence
	sequence s_eval;
		scan_req && state == LMS_ST_EVAL;
	endsequence
	property p_scan;
		s_read |=> s_eval;
	endproperty
	a_scan: assert property (p_scan)
		else $error("scan did not evaluate");
	property p_discard;
		ce && state == LMS_ST_CHECK && nv.entry_cut |=> discard_prog;
	endproperty
	a_discard: assert property (p_discard)
		else $error("interrupted program not discarded");
	property p_const;
		image.one == LMS_ONE && image.zero == LMS_ZERO;
	endproperty
	a_const: assert property (p_const)
		else $error("constant sources wrong");
	property p_dual;
		ce && state == LMS_ST_READ && dual_use_analog[0]
			|=> image.di[LMS_DUAL_POS] == 1'b0;
	endproperty
	a_dual: assert property (p_dual)
		else $error("analog pin read as digital");
	property p_retain;
		ce && $rose(pf_sync) && nv.retain_any |=> retain_store;
	endproperty
	a_retain: assert property (p_retain)
		else $error("retentive values not stored");
	property p_dl_run;
		ce && state == LMS_ST_CHECK && strap_dl && !nv.module_valid
			&& has_prog |=> run_state && led_green;
	endproperty
	a_dl_run: assert property (p_dl_run)
		else $error("display-less unit did not run");

endmodule

/* File: tb/lms_field.sv */
// Program engine model that answers each go pulse driven by the bench
`timescale 1ns/100ps
module lms_field
	import lms_pkg::*;
(
	input wire logic clk,
	input wire logic go,
	input wire lms_result_s res,
	output logic eval_done,
	output lms_result_s eval_result
);
	initial begin
		eval_done = 1'h0;
		eval_result = '0;
	end
	always @(posedge clk) begin
		eval_done <= #2 go;
		eval_result <= #2 go ? res : ~eval_result;
	end
endmodule

/* File: tb/lms_sequencer_test.sv */
// Self-checking bench for the run/stop sequencer
`timescale 1ns/100ps
module lms_sequencer_test
	import lms_pkg::*;
;
	logic clk = 1'h0, rst = 1'h1, ce = 1'h1, strap = 1'h0;
	logic copy_done, start_cmd, stop_cmd, pf, go, eval_done, scan_req;
	logic run, prompt, copy_req, disc, rstore, rrest, lg, lr;
	lms_nv_s nv;
	logic [23:0] di;
	logic [7:0][9:0] ai;
	logic [1:0] dual;
	logic [3:0] slot;
	logic [7:0] rflags, m;
	logic [15:0] q, exp_q;
	logic [31:0] r;
	logic [45:0] nt;
	logic [45:0] notes[$];
	lms_result_s res, eval_result;
	lms_image_s image;
	int failures = 0, samples_checked = 0, k, i, j;
	int n_disc = 0, n_store = 0, n_rest = 0, n_scan = 0;
	integer seed = 32'h985f;

	lms_sequencer i_dut (.clk(clk), .rst(rst), .ce(ce),
		.displayless_variant(strap), .nv(nv), .copy_done(copy_done),
		.start_cmd(start_cmd), .stop_cmd(stop_cmd), .power_fail_pin(pf),
		.digital_input_range(di), .analog_channel_range(ai),
		.dual_use_analog(dual), .slot_comm(slot), .retained_flags(rflags),
		.eval_done(eval_done), .eval_result(eval_result), .image(image),
		.scan_req(scan_req), .switched_output_range(q),
		.flag_bit_range(m), .run_state(run), .prompt_no_prog(prompt),
		.copy_req(copy_req), .discard_prog(disc), .retain_store(rstore),
		.retain_restore(rrest), .led_green(lg), .led_red(lr));
	lms_field i_field (.clk(clk), .go(go), .res(res),
		.eval_done(eval_done), .eval_result(eval_result));

	always #12.5 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h",
				$time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("Checks %0d, failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic pulse(ref logic s);
		s = 1'h1;
		step(1);
		s = 1'h0;
	endtask

	// Reset held 4 cycles, answer settled 4 edges after release
	task automatic boot(input lms_nv_s v, input logic s);
		rst = 1'h1;
		nv = v;
		strap = s;
		step(4);
		rst = 1'h0;
		step(4);
	endtask

	task automatic wait_scan;
		int n;
		n = 0;
		while (scan_req !== 1'h1 && n < 50) begin
			step(1);
			n++;
		end
		if (n == 50) failures++;
		step(1);
	endtask

	function automatic logic [15:0] qmask(input logic [3:0] s);
		logic [15:0] x;
		x = 16'h000F;
		for (int b = 0; b < 4; b++) if (s[b]) x |= 16'h0007 << (4 + 3 * b);
		return x;
	endfunction

	// Expansion input bits 8..23 that a communicating slot owns
	function automatic logic [15:0] dmask(input logic [3:0] s);
		logic [15:0] x;
		x = 16'h0000;
		for (int b = 0; b < 4; b++) if (s[b]) x |= 16'h000F << (4 * b);
		return x;
	endfunction

	// Pulse counters and image watcher
	always @(posedge clk) begin
		n_disc += (disc === 1'h1);
		n_store += (rstore === 1'h1);
		n_rest += (rrest === 1'h1);
		n_scan += (scan_req === 1'h1);
		if (scan_req === 1'h1 && notes.size() > 0) begin
			nt = notes.pop_front();
			check({image.di[7:0], image.ai[1], image.ai[0], image.one,
				image.zero}, nt[29:0]);
			check(image.di[23:8], nt[45:30]);
		end
	end

	initial begin
		#150000;
		failures++;
		tally_and_finish;
	end

	initial begin
		{copy_done, start_cmd, stop_cmd, pf, go} = 5'h00;
		{di, ai, dual, slot, res} = '0;
		nv = '0;
		r = $random(seed);
		rflags = r[7:0];
		boot(5'h00, 1'h0);
		check({prompt, run, lg, lr}, 4'h8);
		pulse(start_cmd);
		step(1);
		check(run, 1'h0);
		k = n_disc;
		boot(5'h12, 1'h0);
		check({n_disc - k, prompt}, 2'h3);
		boot(5'h10, 1'h0);
		check({run, prompt}, 2'h0);
		k = n_rest;
		boot(5'h0D, 1'h0);
		check(copy_req, 1'h1);
		pulse(copy_done);
		step(2);
		check({copy_req, run}, 2'h1);
		check(n_rest - k, 1);
		check(m, rflags);
		for (i = 0; i < 8; i++) begin
			if (i > 0) begin
				wait_scan;
				check({m, q}, {res.m, exp_q});
			end
			r = $random(seed);
			di = r[23:0];
			for (j = 0; j < 8; j++) begin
				r = $random(seed);
				ai[j] = r[9:0];
			end
			r = $random(seed);
			{dual, slot} = r[29:24];
			res = r[23:0];
			exp_q = res.q & qmask(slot);
			notes.push_back({di[23:8] & dmask(slot),
				di[7:0] & ~{dual, 6'h00},
				dual[1] ? ai[1] : 10'h000, dual[0] ? ai[0] : 10'h000, 2'h2});
			step(8);
			pulse(go);
		end
		wait_scan;
		check(q, exp_q);
		pulse(stop_cmd);
		check({run, q}, 17'h00000);
		k = n_scan;
		pulse(go);
		di = ~di;
		step(10);
		check({n_scan - k, q}, 0);
		k = n_store;
		pf = 1'h1;
		step(8);
		check(n_store - k, 1);
		pf = 1'h0;
		boot(5'h10, 1'h1);
		check({run, lg, lr}, 3'h6);
		pulse(stop_cmd);
		check({run, lg, lr}, 3'h1);
		pulse(start_cmd);
		step(2);
		check({run, lg, lr}, 3'h6);
		ce = 1'h0;
		pulse(stop_cmd);
		step(2);
		check({run, lg, lr}, 3'h6);
		ce = 1'h1;
		tally_and_finish;
	end
endmodule
